/* File: adl_map.svh */
// Constants for the auto-dial digit interface: register map, fields, resets
`ifndef ADL_MAP_SVH
`define ADL_MAP_SVH

// Register byte offsets
`define ADL_OFF_CTRL    4'h0
`define ADL_OFF_DATA    4'h4
`define ADL_OFF_STATUS  4'h8
`define ADL_OFF_IRQ_ST  4'hc
`define ADL_OFF_MSK     5'h10

// Byte address width seen by the decoder
`define ADL_ADDR_W      5

// Control register fields
`define ADL_CTRL_SEL    0
`define ADL_CTRL_OUT    1

// Status register fields
`define ADL_STAT_PRES   0
`define ADL_STAT_REQ    1
`define ADL_STAT_RDY    2

// Digit field
`define ADL_DIGIT_W     4
`define ADL_DIGIT_LSB   0

// Interrupt status fields
`define ADL_IRQ_W       2
`define ADL_IRQ_READY   0
`define ADL_IRQ_TAKEN   1

// Reset values
`define ADL_RST_DIGIT   4'h0
`define ADL_RST_CTRL    2'h0
`define ADL_RST_IRQ     2'h0

`endif

/* File: adl_pkg.sv */
// Types shared by the auto-dial digit interface modules
package adl_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [4:0]  adr;
        logic [31:0] dat;
    } adl_wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } adl_wb_rsp_t;

    // Lines toward the calling unit
    typedef struct packed {
        logic [3:0] digit;
        logic       present;
    } adl_dial_t;

    // Presentation handshake state
    typedef enum logic [1:0] {
        ADL_IDLE    = 2'b00,
        ADL_PRESENT = 2'b01,
        ADL_WAIT    = 2'b10
    } adl_state_t;

endpackage

/* File: adl_edge.sv */
// Rising-edge detector for the next-digit request line
`timescale 1ns/10ps
`default_nettype none

module adl_edge (
    input  wire logic mclk_in,   // System clock
    input  wire logic rst_n_in,  // Asynchronous reset, active low
    input  wire logic level_in,  // Synchronous level
    output logic      rise_out   // One-cycle pulse on rising edge
);
    logic prev;

    // Previous sample of the level
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev <= 1'b0;
        end else begin
            prev <= level_in;
        end
    end

    assign rise_out = level_in & ~prev;
endmodule
`default_nettype wire

/* File: adl_irq.sv */
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/10ps
`default_nettype none

module adl_irq #(
    parameter int W = 2                        // Number of event bits
) (
    input  wire logic         mclk_in,        // System clock
    input  wire logic         rst_n_in,       // Asynchronous reset, active low
    input  wire logic [W-1:0] event_in,       // Event pulses
    input  wire logic [W-1:0] clear_in,       // Write-one-to-clear bits
    input  wire logic         clear_we_in,    // Clear strobe
    input  wire logic [W-1:0] mask_in,        // Enable mask
    output logic      [W-1:0] status_out,     // Sticky status
    output logic              irq_out         // Level interrupt
);
    logic [W-1:0] next_status;

    // Set wins over clear so an event in the clear cycle survives
    assign next_status = (status_out & ~(clear_we_in ? clear_in : '0)) | event_in;

    // Status flops
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_out <= '0;
        end else begin
            status_out <= next_status;
        end
    end

    assign irq_out = |(status_out & mask_in);
endmodule
`default_nettype wire

/* File: adl_top.sv */
// Auto-dial digit interface: Wishbone registers, digit latches, dialer handshake
// =====================================================================
// Notes on behaviour
// R1: Dialing path works only while the dial select bit is set.
// R2: Each dial strobe loads low data bits into digit latches, driven continuously.
// R3: Dial strobe sets the digit-present flag, shown to the calling unit.
// R4: Rising next-digit request clears the digit-present flag.
// R5: Reset clears digit-present flag, digit latches and all other flops.
// R6: Ready term needs request low, flag clear, output direction, dial enable.
// R7: An output-data write addressed here makes the output register strobe.
// R8: Software writes next digit only after seeing the ready indication.
`timescale 1ns/10ps
`default_nettype none

`include "adl_map.svh"

module adl_top (
    input  wire logic         mclk_in,                // System clock, 10 MHz
    input  wire logic         rst_n_in,               // Master clear, active low
    input  wire logic         wb_cyc_in,              // Wishbone cycle
    input  wire logic         wb_stb_in,              // Wishbone strobe
    input  wire logic         wb_we_in,               // Wishbone write enable
    input  wire logic [3:0]   wb_sel_in,              // Wishbone byte selects
    input  wire logic [4:0]   wb_adr_in,              // Wishbone byte address
    input  wire logic [31:0]  wb_dat_in,              // Wishbone write data
    output logic              wb_ack_out,             // Wishbone acknowledge
    output logic      [31:0]  wb_dat_out,             // Wishbone read data
    output adl_pkg::adl_dial_t dial_out,              // Digit lines and digit present
    input  wire logic         next_digit_request_in,  // Calling unit wants next digit
    output logic              dial_ready_term_out,    // Ready term into buffer ready
    output logic              irq_out                 // Level interrupt
);
    import adl_pkg::*;

    // =================================================================
    // Bus decode
    logic        ack;
    logic [31:0] rdata;
    logic        dial_select_bit;
    logic        dir_output;
    logic [3:0]  digit;
    logic        digit_present_flag;
    logic [`ADL_IRQ_W-1:0] irq_mask;
    logic [`ADL_IRQ_W-1:0] irq_status;
    logic        req_rise;
    logic        prev_ready;

    wire req       = wb_cyc_in & wb_stb_in & ~ack;
    wire wr        = req & wb_we_in;
    wire hit_ctrl  = (wb_adr_in == {1'b0, `ADL_OFF_CTRL});
    wire hit_data  = (wb_adr_in == {1'b0, `ADL_OFF_DATA});
    wire hit_stat  = (wb_adr_in == {1'b0, `ADL_OFF_STATUS});
    wire hit_irq   = (wb_adr_in == {1'b0, `ADL_OFF_IRQ_ST});
    wire hit_msk   = (wb_adr_in == `ADL_OFF_MSK);
    wire lane0     = wb_sel_in[0];
    wire wr_ctrl   = wr & hit_ctrl & lane0;
    wire wr_irq    = wr & hit_irq & lane0;
    wire wr_msk    = wr & hit_msk & lane0;

    // Output register strobe: output-data write to this unit
    wire output_reg_strobe = wr & hit_data & lane0;  // R7
    wire dial_enable       = dial_select_bit;
    // Strobe reaches dial logic only in dial mode
    wire dial_reg_strobe   = output_reg_strobe & dial_enable;  // R1

    // =================================================================
    // Acknowledge: one cycle after request, dropped the next cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req;
        end
    end

    // Read data registered with the ack; unmapped reads as zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata[`ADL_CTRL_SEL] = dial_select_bit;
            rdata[`ADL_CTRL_OUT] = dir_output;
        end else if (hit_data) begin
            rdata[`ADL_DIGIT_W-1:0] = digit;
        end else if (hit_stat) begin
            rdata[`ADL_STAT_PRES] = digit_present_flag;
            rdata[`ADL_STAT_REQ]  = next_digit_request_in;
            rdata[`ADL_STAT_RDY]  = dial_ready_term_out;
        end else if (hit_irq) begin
            rdata[`ADL_IRQ_W-1:0] = irq_status;
        end else if (hit_msk) begin
            rdata[`ADL_IRQ_W-1:0] = irq_mask;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (req & ~wb_we_in) begin
            wb_dat_out <= rdata;
        end
    end

    assign wb_ack_out = ack;

    // =================================================================
    // Control register: dial select and output direction
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dial_select_bit <= 1'b0;  // R5
            dir_output      <= 1'b0;
        end else if (wr_ctrl) begin
            dial_select_bit <= wb_dat_in[`ADL_CTRL_SEL];  // R1
            dir_output      <= wb_dat_in[`ADL_CTRL_OUT];
        end
    end

    // Mask register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask <= `ADL_RST_IRQ;
        end else if (wr_msk) begin
            irq_mask <= wb_dat_in[`ADL_IRQ_W-1:0];
        end
    end

    // =================================================================
    // Digit latches, held steady between dial strobes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            digit <= `ADL_RST_DIGIT;  // R5
        end else if (dial_reg_strobe) begin
            digit <= wb_dat_in[`ADL_DIGIT_LSB +: `ADL_DIGIT_W];  // R2
        end
    end

    // Edge of the next-digit request acts as the flag's trigger
    adl_edge u_edge (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .level_in (next_digit_request_in),
        .rise_out (req_rise)
    );

    // Digit-present flag: strobe sets directly, request edge resets.
    // The strobe wins if both land together so a fresh digit is never lost.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            digit_present_flag <= 1'b0;  // R5
        end else if (dial_reg_strobe) begin
            digit_present_flag <= 1'b1;  // R3
        end else if (req_rise) begin
            digit_present_flag <= 1'b0;  // R4
        end
    end

    // Digit lines and digit present leave as one word, one driver for the port
    assign dial_out = '{digit   : digit,                // R2
                        present : digit_present_flag};  // R3

    // Ready term feeds buffer ready; software must wait for it (R8)
    assign dial_ready_term_out = ~next_digit_request_in & ~digit_present_flag
                                 & dir_output & dial_enable;  // R6

    // =================================================================
    // Interrupt events: ready term rising, digit taken by the dialer
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_ready <= 1'b0;
        end else begin
            prev_ready <= dial_ready_term_out;
        end
    end

    wire [`ADL_IRQ_W-1:0] irq_events = {req_rise & digit_present_flag,
                                        dial_ready_term_out & ~prev_ready};

    adl_irq #(
        .W (`ADL_IRQ_W)
    ) u_irq (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .event_in    (irq_events),
        .clear_in    (wb_dat_in[`ADL_IRQ_W-1:0]),
        .clear_we_in (wr_irq),
        .mask_in     (irq_mask),
        .status_out  (irq_status),
        .irq_out     (irq_out)
    );

    // =================================================================
    // Checks
    a_ack_one_cycle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        wb_ack_out |=> !wb_ack_out) else $error("ack held more than one cycle");
    a_ack_follows: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
        else $error("ack missing after request");
    a_strobe_sets_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R3
        dial_reg_strobe |=> dial_out.present) else $error("present not set");
    a_strobe_loads_digit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R2
        dial_reg_strobe |=> dial_out.digit == $past(wb_dat_in[`ADL_DIGIT_LSB +: `ADL_DIGIT_W]))
        else $error("digit not loaded");
    a_request_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R4
        (req_rise && !dial_reg_strobe) |=> !dial_out.present)
        else $error("present not cleared");
    a_idle_unselected: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R1
        (!dial_select_bit && $stable(dial_select_bit) && !dial_out.present)
        |=> !dial_out.present) else $error("dial path active when unselected");
    a_ready_term: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R6
        dial_ready_term_out |-> (!dial_out.present && !next_digit_request_in
        && dir_output && dial_select_bit)) else $error("ready term wrong");
    a_digit_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R2
        !dial_reg_strobe |=> $stable(dial_out.digit)) else $error("digit changed");
    a_unsel_digit_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R1
        (output_reg_strobe && !dial_enable) |=> $stable(dial_out.digit))
        else $error("digit loaded while unselected");
    a_ready_when_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R6
        (!next_digit_request_in && !dial_out.present && dir_output && dial_select_bit)
        |-> dial_ready_term_out) else $error("ready term missing");
    a_ready_event_sets: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (dial_ready_term_out && !prev_ready) |=> irq_status[`ADL_IRQ_READY])
        else $error("ready event lost");
    a_taken_event_sets: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // R4
        (req_rise && digit_present_flag) |=> irq_status[`ADL_IRQ_TAKEN])
        else $error("digit taken event lost");
endmodule
`default_nettype wire

/* File: adl_dialer_model.sv */
// Behavioural model of the calling unit on the dial lines
`timescale 1ns/10ps
`default_nettype none

module adl_dialer_model (
    input  wire logic               mclk_in,    // System clock
    input  wire logic               rst_n_in,   // Reset, active low
    input  wire adl_pkg::adl_dial_t dial_in,    // Digit lines and digit present
    input  wire logic [3:0]         delay_in,   // Cycles before taking a digit
    output logic                    req_out,    // Next-digit request
    output logic      [3:0]         digit_out   // Last digit taken
);
    import adl_pkg::*;
    logic [4:0] cnt;

    // ==========================================================
    // Take a digit after a delay, then hold the request until present clears
    // The request is never dropped early: a short pulse could be missed
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_out   <= 1'b0;
            digit_out <= 4'h0;
            cnt       <= 5'h00;
        end else if (!req_out && dial_in.present) begin
            cnt <= cnt + 5'h01;
            if (cnt == {1'b0, delay_in}) begin
                req_out   <= 1'b1;
                digit_out <= dial_in.digit;
                cnt       <= 5'h00;
            end
        end else if (req_out) begin
            cnt <= cnt + 5'h01;
            if (cnt >= 5'h03 && !dial_in.present) begin
                req_out <= 1'b0;
                cnt     <= 5'h00;
            end
        end else begin
            cnt <= 5'h00;
        end
    end
endmodule

`default_nettype wire

/* File: tb_adl_top.sv */
// Self-checking testbench for the auto-dial digit interface
`timescale 1ns/10ps
`default_nettype none
`include "adl_map.svh"

module tb_adl_top;
    import adl_pkg::*;
    logic        mclk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, rd, seed = 32'h270e;
    logic        ack, req, ready, irq;
    logic [3:0]  delay = 4'h1, taken, d;
    adl_dial_t   dial;
    int          n_errors = 0;
    int          total_checks = 0;

    // ==========================================================
    // Clock and instances
    always #50 mclk_in = ~mclk_in;
    adl_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_sel_in(4'hf), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_ack_out(ack),
        .wb_dat_out(rdat), .dial_out(dial), .next_digit_request_in(req),
        .dial_ready_term_out(ready), .irq_out(irq));
    adl_dialer_model unit (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .dial_in(dial),
        .delay_in(delay), .req_out(req), .digit_out(taken));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task complete_run;
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic single cycle; the slave latency is not assumed
    task wb(input logic w, input logic [4:0] a, input logic [31:0] dat);
        int t;
        @(posedge mclk_in);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= dat;
        t = 0;
        do begin @(posedge mclk_in); t++; end while (ack !== 1'b1 && t < 20);
        chk("wb_ack", 32'h1, {31'h0, ack});
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(negedge mclk_in);
    endtask

    // Bounded wait for a level on present or ready
    task wait_sig(input logic use_ready, input logic v);
        int t;
        t = 0;
        while ((use_ready ? ready : dial.present) !== v && t < 100) begin
            @(negedge mclk_in);
            t++;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(negedge mclk_in);
        chk("dial_reset", 32'h0, {27'h0, dial});
        chk("ready_reset", 32'h0, {31'h0, ready});
        wb(1'b1, `ADL_OFF_DATA, 32'h5);
        chk("dial_unselected", 32'h0, {27'h0, dial});
        wb(1'b0, 5'h14, 32'h0);
        chk("unmapped_read", 32'h0, rd);
        wb(1'b1, `ADL_OFF_CTRL, 32'h3);
        chk("ready_idle", 32'h1, {31'h0, ready});
        wb(1'b1, `ADL_OFF_MSK, 32'h1);
        wb(1'b1, `ADL_OFF_IRQ_ST, 32'h3);
        // Random digits with corner values first; high data bits are noise
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            delay = seed[7:4];
            d = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : seed[3:0];
            wait_sig(1'b1, 1'b1);
            chk("ready_before", 32'h1, {31'h0, ready});
            wb(1'b1, `ADL_OFF_DATA, {seed[31:4], d});
            chk("digit", {28'h0, d}, {28'h0, dial.digit});
            wb(1'b0, `ADL_OFF_DATA, 32'h0);
            chk("digit_read", {28'h0, d}, {28'h0, rd[3:0]});
            wait_sig(1'b0, 1'b0);
            chk("present_clear", 32'h0, {31'h0, dial.present});
            chk("digit_taken", {28'h0, d}, {28'h0, taken});
            wait_sig(1'b1, 1'b1);
            // Status bit lands on the edge after the ready term rises
            @(negedge mclk_in);
            chk("irq_set", 32'h1, {31'h0, irq});
            wb(1'b0, `ADL_OFF_IRQ_ST, 32'h0);
            chk("irq_status", 32'h3, rd);
            wb(1'b1, `ADL_OFF_IRQ_ST, 32'h3);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
        // Slow unit: digit held, ready low, then direction off and reset
        delay = 4'hf;
        wb(1'b1, `ADL_OFF_DATA, 32'ha);
        chk("present_set", 32'h1, {31'h0, dial.present});
        chk("ready_busy", 32'h0, {31'h0, ready});
        wb(1'b0, `ADL_OFF_STATUS, 32'h0);
        chk("status_busy", 32'h1, rd);
        wait_sig(1'b1, 1'b1);
        wb(1'b1, `ADL_OFF_CTRL, 32'h1);
        chk("ready_dir_off", 32'h0, {31'h0, ready});
        wb(1'b1, `ADL_OFF_CTRL, 32'h3);
        wb(1'b1, `ADL_OFF_DATA, 32'h9);
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        @(negedge mclk_in);
        chk("dial_midreset", 32'h0, {27'h0, dial});
        // Release again: control, ready and interrupt must come back cleared
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(negedge mclk_in);
        chk("ready_midreset", 32'h0, {31'h0, ready});
        chk("irq_midreset", 32'h0, {31'h0, irq});
        wb(1'b0, `ADL_OFF_CTRL, 32'h0);
        chk("ctrl_midreset", 32'h0, rd);
        complete_run;
    end

    // Watchdog at 20000 cycles, far over the expected run of under a thousand cycles
    initial begin
        #2000000;
        n_errors++;
        complete_run;
    end
endmodule

`default_nettype wire
